// >>> hw/soft_switch_device.sv
// Two expanders on the two-wire link; the first one's port A drives board switch enables
//
// Function
// - host configures both expanders over two-wire link
// - port outputs at 0x12 and 0x13
// - all pins are inputs after power-up
// - direction zero makes output; 0x00, 0x01
// - host programs pins output, even keeping defaults
// - per-address board defaults A/B values
// - first expander addressed 0100001 plus direction bit
// - A3 flash select, A4 quad lines, high
// - A5 serial bridge, A6 flow control, low
// - boot selector codes zero to five
// - indicator LEDs are active high
`timescale 1ns/1ns
module soft_switch_device
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Two-wire link
    two_wire_if.device      link,
    // Boot selector strap
    input  wire logic [2:0] boot_strap,
    // Board switch enables
    output logic      [2:0] led_on,
    output logic            flash_select_path_en,
    output logic            flash_quad_lines_en,
    output logic            serial_bridge_en,
    output logic            serial_flow_ctrl_en,
    output logic      [2:0] boot_mode
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_ADDR = 5'h02,
        S_REG  = 5'h04,
        S_DATA = 5'h08,
        S_ACK  = 5'h10
    } dev_state_t;

    // ------------------------------------------------------------------
    // Input synchronisers: a change counts once stages two and three agree
    // ------------------------------------------------------------------
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic       scl_ff;
    logic       sda_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff      <= 1'b1;
            sda_ff      <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], link.scl};
            sda_sync_ff <= {sda_sync_ff[1:0], link.sda};
            if (scl_sync_ff[1] == scl_sync_ff[2])
                scl_ff <= scl_sync_ff[2];
            if (sda_sync_ff[1] == sda_sync_ff[2])
                sda_ff <= sda_sync_ff[2];
        end
    end
    logic scl_q;
    logic sda_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_ff;
            sda_q <= sda_ff;
        end
    end
    wire scl_rise = scl_ff && !scl_q;
    wire scl_fall = !scl_ff && scl_q;
    wire start_c  = scl_ff && scl_q && !sda_ff && sda_q;
    wire stop_c   = scl_ff && scl_q && sda_ff && !sda_q;

    // ------------------------------------------------------------------
    // Byte receiver and transaction state
    // ------------------------------------------------------------------
    dev_state_t state_ff;
    dev_state_t ret_ff;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic [1:0] sel_ff;
    logic [7:0] reg_ptr_ff;
    logic       ack_drv_ff;
    logic       wr_en_ff;
    wire  [6:0] addr7 = shift_ff[7:1];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= S_IDLE;
            ret_ff     <= S_IDLE;
            shift_ff   <= 8'h00;
            bit_cnt_ff <= 4'h0;
            sel_ff     <= 2'h0;
            reg_ptr_ff <= 8'h00;
            ack_drv_ff <= 1'b0;
            wr_en_ff   <= 1'b0;
        end
        else
        begin
            wr_en_ff <= 1'b0;
            if (start_c)
            begin
                state_ff   <= S_ADDR;
                bit_cnt_ff <= 4'h0;
                ack_drv_ff <= 1'b0;
            end
            else if (stop_c)
            begin
                state_ff   <= S_IDLE;
                ack_drv_ff <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    S_IDLE: ;
                    S_ADDR, S_REG, S_DATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_ff   <= {shift_ff[6:0], sda_ff};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_ff == 4'h8)
                        begin
                            bit_cnt_ff <= 4'h0;
                            state_ff   <= S_ACK;
                            // Address must match one expander, writes only
                            if (state_ff == S_ADDR)
                            begin
                                if (!shift_ff[0] && addr7 == soft_switch_pkg::ADDR_EXPANDER_1)
                                begin
                                    sel_ff     <= 2'h1;
                                    ack_drv_ff <= 1'b1;
                                    ret_ff     <= S_REG;
                                end
                                else if (!shift_ff[0]
                                         && addr7 == soft_switch_pkg::ADDR_EXPANDER_2)
                                begin
                                    sel_ff     <= 2'h2;
                                    ack_drv_ff <= 1'b1;
                                    ret_ff     <= S_REG;
                                end
                                else
                                begin
                                    state_ff <= S_IDLE;
                                end
                            end
                            else if (state_ff == S_REG)
                            begin
                                reg_ptr_ff <= shift_ff;
                                ack_drv_ff <= 1'b1;
                                ret_ff     <= S_DATA;
                            end
                            else
                            begin
                                wr_en_ff   <= 1'b1;
                                ack_drv_ff <= 1'b1;
                                ret_ff     <= S_IDLE;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        // Release the line after the ninth clock pulse
                        if (scl_fall)
                        begin
                            ack_drv_ff <= 1'b0;
                            state_ff   <= ret_ff;
                        end
                    end
                    default: state_ff <= S_IDLE;
                endcase
            end
        end
    end
    assign link.sda_dev_o  = 1'b0;
    assign link.sda_dev_oe = ack_drv_ff;

    // ------------------------------------------------------------------
    // Two expanders, one generate loop
    // ------------------------------------------------------------------
    logic [7:0] dir_a [2];
    logic [7:0] dir_b [2];
    logic [7:0] out_a [2];
    logic [7:0] out_b [2];
    logic [7:0] pin_a [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_exp
            expander_regs u_regs
            (
                .pclk    (pclk),
                .presetn (presetn),
                .wr_en   (wr_en_ff && sel_ff == 2'(g + 1)),
                .wr_reg  (reg_ptr_ff),
                .wr_data (shift_ff),
                .dir_a   (dir_a[g]),
                .dir_b   (dir_b[g]),
                .out_a   (out_a[g]),
                .out_b   (out_b[g])
            );
            // Input pins fall back to the board pull levels
            assign pin_a[g] = (out_a[g] & ~dir_a[g])
                            | (soft_switch_pkg::PORT_A_PULL & dir_a[g]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Board enables from the first expander's port A; port B unused
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_on               <= 3'h0;
            flash_select_path_en <= 1'b1;
            flash_quad_lines_en  <= 1'b1;
            serial_bridge_en     <= 1'b0;
            serial_flow_ctrl_en  <= 1'b0;
        end
        else
        begin
            led_on               <= pin_a[0][soft_switch_pkg::BIT_LED2:
                                              soft_switch_pkg::BIT_LED0];
            flash_select_path_en <= pin_a[0][soft_switch_pkg::BIT_FLASH_SELECT];
            flash_quad_lines_en  <= pin_a[0][soft_switch_pkg::BIT_FLASH_QUAD];
            serial_bridge_en     <= pin_a[0][soft_switch_pkg::BIT_SERIAL_BRIDGE];
            serial_flow_ctrl_en  <= pin_a[0][soft_switch_pkg::BIT_SERIAL_FLOW];
        end
    end

    // Strap pin passes three flops; a change counts once stages two and three agree
    logic [8:0] boot_sync_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_sync_ff <= {3{soft_switch_pkg::BOOT_DEFAULT}};
            boot_mode    <= soft_switch_pkg::BOOT_DEFAULT;
        end
        else
        begin
            boot_sync_ff <= {boot_sync_ff[5:0], boot_strap};
            if (boot_sync_ff[5:3] == boot_sync_ff[8:6])
                boot_mode <= boot_sync_ff[8:6];
        end
    end
endmodule // soft_switch_device

// >>> hw/soft_switch_pkg.sv
// Shared constants for the soft switch expander link
package soft_switch_pkg;
    // ------------------------------------------------------------------
    // Expander register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_PORT_A_DIRECTION = 8'h00;
    localparam logic [7:0] REG_PORT_B_DIRECTION = 8'h01;
    localparam logic [7:0] REG_PORT_A_OUTPUT    = 8'h12;
    localparam logic [7:0] REG_PORT_B_OUTPUT    = 8'h13;
    localparam logic [7:0] DIRECTION_RESET      = 8'hFF;
    localparam logic [7:0] OUTPUT_RESET         = 8'h00;

    // ------------------------------------------------------------------
    // Bus addresses and board defaults
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_EXPANDER_1      = 7'h21;
    localparam logic [6:0] ADDR_EXPANDER_2      = 7'h22;
    localparam logic [7:0] EXP1_DEFAULT_A       = 8'h02;
    localparam logic [7:0] EXP1_DEFAULT_B       = 8'hC4;
    localparam logic [7:0] EXP2_DEFAULT_A       = 8'hE0;
    localparam logic [7:0] EXP2_DEFAULT_B       = 8'hFF;

    // ------------------------------------------------------------------
    // Port A bit positions
    // ------------------------------------------------------------------
    localparam int BIT_LED0                     = 0;
    localparam int BIT_LED2                     = 2;
    localparam int BIT_FLASH_SELECT             = 3;
    localparam int BIT_FLASH_QUAD               = 4;
    localparam int BIT_SERIAL_BRIDGE            = 5;
    localparam int BIT_SERIAL_FLOW              = 6;
    // Board pull levels seen while a pin is still an input
    localparam logic [7:0] PORT_A_PULL          = 8'h18;

    // ------------------------------------------------------------------
    // Boot selector encoding
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BOOT_NONE      = 3'h0,
        BOOT_SPI_MST   = 3'h1,
        BOOT_SPI_SLV   = 3'h2,
        BOOT_UART      = 3'h3,
        BOOT_LINK      = 3'h4,
        BOOT_OSPI_MST  = 3'h5,
        BOOT_RSVD6     = 3'h6,
        BOOT_RSVD7     = 3'h7
    } boot_mode_t;
    localparam logic [2:0] BOOT_DEFAULT         = 3'h1;

    // ------------------------------------------------------------------
    // Host APB register map and two-wire timing
    // ------------------------------------------------------------------
    localparam logic [11:0] APB_CMD             = 12'h000;
    localparam logic [11:0] APB_STATUS          = 12'h004;
    localparam logic [11:0] APB_BOOT            = 12'h008;
    localparam int          CMD_GO_BIT          = 31;
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          SCL_HALF_NS         = 2500;
    localparam int          SCL_HALF_CYC        = SCL_HALF_NS / CLK_PERIOD_NS;
    localparam logic [8:0]  SCL_HALF_LAST       = 9'(SCL_HALF_CYC - 1);
endpackage

// >>> hw/two_wire_if.sv
// Two-wire link between host controller and expanders
`timescale 1ns/1ns
interface two_wire_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;
    // Open drain: the line is low while any end drives low
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

    modport host   (output scl, output sda_host_o, output sda_host_oe, input sda);
    modport device (input scl, output sda_dev_o, output sda_dev_oe, input sda);
endinterface

// >>> hw/expander_regs.sv
// One eight-bit-per-port expander register set
`timescale 1ns/1ns
module expander_regs
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Write strobe
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_reg,
    input  wire logic [7:0] wr_data,
    // Port state
    output logic      [7:0] dir_a,
    output logic      [7:0] dir_b,
    output logic      [7:0] out_a,
    output logic      [7:0] out_b
);
    // Pins power up as inputs and outputs latch zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_a <= soft_switch_pkg::DIRECTION_RESET;
            dir_b <= soft_switch_pkg::DIRECTION_RESET;
            out_a <= soft_switch_pkg::OUTPUT_RESET;
            out_b <= soft_switch_pkg::OUTPUT_RESET;
        end
        else if (wr_en)
        begin
            case (wr_reg)
                soft_switch_pkg::REG_PORT_A_DIRECTION: dir_a <= wr_data;
                soft_switch_pkg::REG_PORT_B_DIRECTION: dir_b <= wr_data;
                soft_switch_pkg::REG_PORT_A_OUTPUT:    out_a <= wr_data;
                soft_switch_pkg::REG_PORT_B_OUTPUT:    out_b <= wr_data;
                default: ;
            endcase
        end
    end
endmodule // expander_regs

// >>> hw/soft_switch_host.sv
// Host two-wire controller, commanded over APB
`timescale 1ns/1ns
module soft_switch_host
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Two-wire link
    two_wire_if.host         link
);
    typedef enum logic [5:0] {
        H_IDLE  = 6'h01,
        H_START = 6'h02,
        H_BIT   = 6'h04,
        H_ACK   = 6'h08,
        H_STOP  = 6'h10,
        H_DONE  = 6'h20
    } host_state_t;

    host_state_t state_ff;
    logic [8:0]  div_ff;
    logic        phase_ff;
    logic [23:0] frame_ff;
    logic [4:0]  bit_ff;
    logic        busy_ff;
    logic        nack_ff;
    logic        done_ff;
    logic [2:0]  boot_ff;
    logic        scl_ff;
    logic        sda_ff;
    wire tick = div_ff == soft_switch_pkg::SCL_HALF_LAST;
    wire acc  = psel && penable;
    wire go   = acc && pwrite && paddr == soft_switch_pkg::APB_CMD
                && pwdata[soft_switch_pkg::CMD_GO_BIT] && !busy_ff;

    // ------------------------------------------------------------------
    // APB: one wait-free access phase; unmapped reads zero with error
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            boot_ff <= soft_switch_pkg::BOOT_DEFAULT;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == soft_switch_pkg::APB_CMD
                        || paddr == soft_switch_pkg::APB_STATUS
                        || paddr == soft_switch_pkg::APB_BOOT);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == soft_switch_pkg::APB_STATUS)
                    prdata <= {29'h0, done_ff, nack_ff, busy_ff};
                else if (paddr == soft_switch_pkg::APB_BOOT)
                    prdata <= {29'h0, boot_ff};
            end
            if (acc && pready && pwrite && paddr == soft_switch_pkg::APB_BOOT)
                boot_ff <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Byte engine: address, register, data in one transaction
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= H_IDLE;
            div_ff   <= 9'h000;
            phase_ff <= 1'b0;
            frame_ff <= 24'h000000;
            bit_ff   <= 5'h00;
            busy_ff  <= 1'b0;
            nack_ff  <= 1'b0;
            done_ff  <= 1'b0;
            scl_ff   <= 1'b1;
            sda_ff   <= 1'b1;
        end
        else
        begin
            div_ff <= (tick || state_ff == H_IDLE) ? 9'h000 : div_ff + 9'h001;
            case (state_ff)
                H_IDLE:
                begin
                    if (go && pready)
                    begin
                        // Command word: [22:16] address, [15:8] reg, [7:0] data
                        frame_ff <= {pwdata[22:16], 1'b0, pwdata[15:0]};
                        busy_ff  <= 1'b1;
                        nack_ff  <= 1'b0;
                        done_ff  <= 1'b0;
                        bit_ff   <= 5'h00;
                        phase_ff <= 1'b0;
                        state_ff <= H_START;
                    end
                end
                H_START:
                    if (tick)
                    begin
                        sda_ff   <= 1'b0;
                        state_ff <= H_BIT;
                    end
                H_BIT, H_ACK:
                    if (tick)
                    begin
                        phase_ff <= !phase_ff;
                        if (!phase_ff)
                        begin
                            scl_ff <= 1'b0;
                        end
                        else
                        begin
                            scl_ff <= 1'b1;
                        end
                        if (!phase_ff && state_ff == H_BIT)
                            sda_ff <= frame_ff[5'd23 - bit_ff];
                        if (!phase_ff && state_ff == H_ACK)
                            sda_ff <= 1'b1;
                        if (phase_ff && state_ff == H_ACK)
                            nack_ff <= nack_ff | link.sda;
                        if (phase_ff && state_ff == H_BIT)
                        begin
                            bit_ff   <= bit_ff + 5'h01;
                            state_ff <= (bit_ff[2:0] == 3'h7) ? H_ACK : H_BIT;
                        end
                        if (phase_ff && state_ff == H_ACK)
                            state_ff <= (bit_ff == 5'd24) ? H_STOP : H_BIT;
                    end
                H_STOP:
                    if (tick)
                    begin
                        phase_ff <= !phase_ff;
                        if (!phase_ff)
                        begin
                            scl_ff <= 1'b0;
                            sda_ff <= 1'b0;
                        end
                        else
                        begin
                            scl_ff   <= 1'b1;
                            state_ff <= H_DONE;
                        end
                    end
                H_DONE:
                    if (tick)
                    begin
                        sda_ff   <= 1'b1;
                        busy_ff  <= 1'b0;
                        done_ff  <= 1'b1;
                        state_ff <= H_IDLE;
                    end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
    assign link.scl         = scl_ff;
    assign link.sda_host_o  = 1'b0;
    assign link.sda_host_oe = !sda_ff;
endmodule // soft_switch_host

// >>> sim/soft_switch_checker.sv
// Protocol assertions on the two-wire link between host and expanders
`timescale 1ns/1ns
module soft_switch_checker
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Framing sequences
    // ------------------------------------------------------------------
    sequence start_cond;
        scl && $fell(sda);
    endsequence
    sequence ack_begin;
        $rose(sda_dev_oe) && !scl;
    endsequence
    // Ack must still be on the line when the ninth clock pulse rises
    sequence ack_to_rise;
        sda_dev_oe [*8] ##[1:300] ($rose(scl) && sda_dev_oe);
    endsequence
    AST_HOST_OPEN_DRAIN: assert property (sda_host_oe |-> !sda_host_o)
        else $error("host drives the data line high");
    AST_DEV_OPEN_DRAIN: assert property (sda_dev_oe |-> !sda_dev_o)
        else $error("expander drives the data line high");
    AST_START_HOLD: assert property (start_cond |-> scl [*8])
        else $error("clock not held high after start");
    AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    AST_ACK_AT_LOW: assert property ($rose(sda_dev_oe) |-> ack_begin)
        else $error("ack driven while clock high");
    AST_ACK_HOLD: assert property (ack_begin |-> ack_to_rise)
        else $error("ack not held into next clock pulse");
    AST_RELEASE_AT_LOW: assert property ($fell(sda_dev_oe) |-> !scl)
        else $error("ack released while clock high");
endmodule // soft_switch_checker

// >>> sim/i2c_soft_switch_expander_tb.sv
// Self-checking bench: APB host controller driving both expanders
`timescale 1ns/1ns
module i2c_soft_switch_expander_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  boot_strap, led_on, boot_mode;
    logic        fsel, fquad, sbr, sflow, err;
    int          mismatches, check_count, cyc;
    two_wire_if lnk();
    soft_switch_host u_soft_switch_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    soft_switch_device u_soft_switch_device (.pclk(pclk), .presetn(presetn), .link(lnk),
        .boot_strap(boot_strap), .led_on(led_on), .flash_select_path_en(fsel),
        .flash_quad_lines_en(fquad), .serial_bridge_en(sbr),
        .serial_flow_ctrl_en(sflow), .boot_mode(boot_mode));
    soft_switch_checker u_soft_switch_checker (.pclk(pclk), .presetn(presetn),
        .scl(lnk.scl), .sda(lnk.sda), .sda_host_o(lnk.sda_host_o),
        .sda_host_oe(lnk.sda_host_oe), .sda_dev_o(lnk.sda_dev_o),
        .sda_dev_oe(lnk.sda_dev_oe));
    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // One register write as a whole link transaction, then wait for done
    task automatic xfer(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d);
        apb(1'b1, soft_switch_pkg::APB_CMD, {8'h80, 1'b0, dev, r, d});
        apb(1'b0, soft_switch_pkg::APB_STATUS, 32'h0);
        chk("busy", 32'h1, {31'h0, rd[0]});
        for (int i = 0; i < 20000 && rd[2] !== 1'b1; i++) apb(1'b0, soft_switch_pkg::APB_STATUS, 32'h0);
        chk("link done", 32'h1, {31'h0, rd[2]});
    endtask
    task automatic outs(input string nm, input logic [6:0] e);
        chk(nm, {25'h0, e}, {25'h0, sflow, sbr, fquad, fsel, led_on});
        $display("test %s done", nm);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Clock, reset and timeout
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Five link writes of about 15000 cycles each fit well inside this ceiling
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; boot_strap = 3'h1; rd = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        outs("reset", 7'h18);
        apb(1'b0, soft_switch_pkg::APB_BOOT, 32'h0);
        chk("boot reg", 32'h1, rd);
        apb(1'b1, soft_switch_pkg::APB_BOOT, 32'h5);
        apb(1'b0, soft_switch_pkg::APB_BOOT, 32'h0);
        chk("boot reg write", 32'h5, {err, rd[30:0]});
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
        for (int i = 0; i < 6; i++)
        begin
            boot_strap <= 3'(i);
            repeat (8) @(posedge pclk);
            chk("boot mode", i, {29'h0, boot_mode});
        end
        xfer(7'h21, 8'h12, 8'h25);
        outs("pins still inputs", 7'h18);
        xfer(7'h21, 8'h00, 8'h00);
        chk("ack seen", 32'h0, {31'h0, rd[1]});
        outs("outputs enabled", 7'h25);
        xfer(7'h23, 8'h12, 8'h7F);
        chk("nack seen", 32'h1, {31'h0, rd[1]});
        outs("wrong address", 7'h25);
        xfer(soft_switch_pkg::ADDR_EXPANDER_1, 8'h12, soft_switch_pkg::EXP1_DEFAULT_A);
        outs("board default", 7'h02);
        xfer(soft_switch_pkg::ADDR_EXPANDER_2, 8'h12, soft_switch_pkg::EXP2_DEFAULT_A);
        chk("second ack", 32'h0, {31'h0, rd[1]});
        outs("second expander", 7'h02);
        results();
    end
endmodule // i2c_soft_switch_expander_tb
